//--- thermal_power_alarm_filter.sv
`timescale 1ns/1ps
`include "thermal_alarm_consts.svh"
// Summary of operation
// - every power sample is low-pass filtered before the threshold compare.
// - power calculation and filter update run at 800 Hz.
// - pole coefficient is sign plus 12-bit magnitude in bits 15:3.
// - discrete mode uses three pole/threshold pairs for transistors 1-2, 3-4, 5-6.
// - linefeed chip present: filter 0 takes total power with first pair settings; the other five keep filtering transistors 2-6.
// - linefeed mode raises power alarm when filtered total exceeds threshold.
// - sensed linefeed link rescales total power from 498 to 1059.6 uW/LSB.
// - any exceeded threshold (only the total's in linefeed mode) forces the line state to OPEN.
// - forced OPEN holds until software writes a line state; ignores masking.
// - six enable bits gate each transistor alarm onto the interrupt.
// - six pending bits set on each transistor's power alarm.
// - linefeed mode uses only the first enable and first pending bit.
// - total dissipated power readable as a 16-bit read-only value.
// - pair 3/4 threshold is a 16-bit value, 31.4 uW resolution.
// - pair 5/6 threshold is a 16-bit value, 498 uW resolution.
// - pending bit set on comparator rising edge, held until cleared.
module thermal_power_alarm_filter
  import thermal_alarm_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic thermal_sense_pin,
  input wire logic [5:0][15:0] transistor_power,
  input wire power_t total_power,
  output logic [2:0] line_state,
  output logic irq
);
  logic tick;
  logic sense_meta;
  logic integrated;
  pair_cfg_s [2:0] cfg;
  filt_out_s [5:0] filt;
  logic [5:0] over_q;
  logic [5:0] mode_mask;
  logic [5:0] alarm_evt;
  logic [5:0] power_alarm_pending_bits;
  logic [5:0] power_alarm_enable_bits;
  logic [31:0] scaled_prod;
  power_t scaled_total;
  power_t total_power_sum;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [5:0] clr_mask;
  logic line_wr;
  logic [31:0] next_rdata;
  logic read_hit;

  // every check samples on aclk and sleeps through reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // merge enabled byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // offsets that answer OKAY
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= `OFS_STATUS);
  endfunction

  // 800 Hz sample strobe
  sample_tick #(.DIV(SAMPLE_DIV)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // the sense pin is asynchronous; only the second stage is used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta <= 1'b0;
      integrated <= 1'b0;
    end else begin
      sense_meta <= thermal_sense_pin;
      integrated <= sense_meta;
    end
  end

  // total power rescaled to the coarser linefeed-chip step
  assign scaled_prod = total_power * `TOTAL_SCALE;
  assign scaled_total = integrated ? scaled_prod[31:16] : total_power;

  // six filters; transistors share their pair's settings, filter 0 takes the total in linefeed mode
  for (genvar i = 0; i < 6; i++) begin : g_filt
    power_t sample;
    if (i == 0) begin : g_first
      assign sample = integrated ? scaled_total : transistor_power[0];
    end else begin : g_rest
      assign sample = transistor_power[i];
    end
    thermal_lpf u_lpf (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .sample(sample),
      .cfg(cfg[i / 2]),
      .out(filt[i])
    );
  end

  // in linefeed mode only the total-power alarm is live
  assign mode_mask = integrated ? 6'h01 : 6'h3F;

  // comparator history for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_q <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) over_q[i] <= filt[i].over;
    end
  end

  // a new excess is an alarm event
  always_comb begin
    for (int i = 0; i < 6; i++) alarm_evt[i] = filt[i].over & ~over_q[i] & mode_mask[i];
  end

  // latest total power, updated once per sample
  always_ff @(posedge aclk) begin
    if (!aresetn) total_power_sum <= 16'h0000;
    else if (tick) total_power_sum <= scaled_total;
  end

  // write channel: address and data taken in either order
  assign awready = !aw_full;
  assign wready = !w_full;
  assign do_write = aw_full && w_full && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= addr_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 3; p++) cfg[p] <= {`RST_THRESHOLD, `RST_POLE};
    end else if (do_write) begin
      unique case (aw_addr_q)
        `OFS_PAIR12_THR: cfg[0].threshold <= merge16(cfg[0].threshold, w_data_q, w_strb_q);
        `OFS_PAIR34_THR: cfg[1].threshold <= merge16(cfg[1].threshold, w_data_q, w_strb_q);
        `OFS_PAIR56_THR: cfg[2].threshold <= merge16(cfg[2].threshold, w_data_q, w_strb_q);
        `OFS_PAIR12_POLE: cfg[0].pole <= merge16(cfg[0].pole, w_data_q, w_strb_q) & `POLE_MASK;
        `OFS_PAIR34_POLE: cfg[1].pole <= merge16(cfg[1].pole, w_data_q, w_strb_q) & `POLE_MASK;
        `OFS_PAIR56_POLE: cfg[2].pole <= merge16(cfg[2].pole, w_data_q, w_strb_q) & `POLE_MASK;
        default: ;
      endcase
    end
  end

  // enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) power_alarm_enable_bits <= `RST_ENABLE;
    else if (do_write && aw_addr_q == `OFS_IRQ_ENABLE && w_strb_q[0]) power_alarm_enable_bits <= w_data_q[5:0];
  end

  assign clr_mask = (do_write && aw_addr_q == `OFS_IRQ_CLEAR && w_strb_q[0]) ? w_data_q[5:0] : 6'h00;
  assign line_wr = do_write && aw_addr_q == `OFS_LINE_STATE && w_strb_q[0];

  // sticky pending bits; a new alarm beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) power_alarm_pending_bits <= 6'h00;
    else power_alarm_pending_bits <= (power_alarm_pending_bits & ~clr_mask) | alarm_evt;
  end

  // interrupt line, masked per transistor
  assign irq = |(power_alarm_pending_bits & power_alarm_enable_bits & mode_mask);

  // line state: alarms force OPEN regardless of masking and win over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) line_state <= `RST_LINE_STATE;
    else if (|alarm_evt) line_state <= `LINE_OPEN;
    else if (line_wr) line_state <= w_data_q[2:0];
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    read_hit = 1'b1;
    unique case (araddr)
      `OFS_TOTAL_SUM: next_rdata[15:0] = total_power_sum;
      `OFS_PAIR12_THR: next_rdata[15:0] = cfg[0].threshold;
      `OFS_PAIR34_THR: next_rdata[15:0] = cfg[1].threshold;
      `OFS_PAIR56_THR: next_rdata[15:0] = cfg[2].threshold;
      `OFS_PAIR12_POLE: next_rdata[15:0] = cfg[0].pole;
      `OFS_PAIR34_POLE: next_rdata[15:0] = cfg[1].pole;
      `OFS_PAIR56_POLE: next_rdata[15:0] = cfg[2].pole;
      `OFS_IRQ_PENDING: next_rdata[5:0] = power_alarm_pending_bits;
      `OFS_IRQ_CLEAR: next_rdata[5:0] = 6'h00;
      `OFS_IRQ_ENABLE: next_rdata[5:0] = power_alarm_enable_bits;
      `OFS_LINE_STATE: next_rdata[2:0] = line_state;
      `OFS_STATUS: next_rdata[6:0] = {integrated, filt[5].over, filt[4].over, filt[3].over,
                                      filt[2].over, filt[1].over, filt[0].over};
      default: read_hit = 1'b0;
    endcase
  end

  // read channel, one request at a time; reads have no side effects
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks
  localparam int unsigned SPACING = SAMPLE_DIV - 1;
  int unsigned since_tick;
  logic seen_tick;

  // cycles since the last sample strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_tick <= 0;
      seen_tick <= 1'b0;
    end else if (tick) begin
      since_tick <= 0;
      seen_tick <= 1'b1;
    end else begin
      since_tick <= since_tick + 1;
    end
  end

  sequence s_first_alarm;
    tick ##1 alarm_evt[0];
  endsequence

  sequence s_alarm_effect;
    power_alarm_pending_bits[0] && line_state == `LINE_OPEN;
  endsequence

  a_tick_spacing: assert property (tick && seen_tick |-> since_tick == SPACING)
    else $error("sample strobe spacing wrong");
  a_filter_hold: assert property (!tick |=> $stable(filt[0].filtered))
    else $error("filter moved without a sample");
  a_frozen_pole: assert property (tick && cfg[1].pole == 16'h0000 |=> $stable(filt[2].filtered))
    else $error("zero pole still moved the filter");
  a_strict_compare: assert property ($rose(filt[1].over) |-> filt[1].filtered > $past(cfg[0].threshold))
    else $error("alarm without strict excess");
  a_alarm_effect: assert property (s_first_alarm |=> s_alarm_effect)
    else $error("alarm did not set pending and force open");
  a_open_holds: assert property (line_state == `LINE_OPEN && !line_wr |=> line_state == `LINE_OPEN)
    else $error("open state left without a write");
  a_linefeed_gate: assert property (integrated |-> alarm_evt[5:1] == 5'h00 && !(irq && !power_alarm_pending_bits[0]))
    else $error("linefeed mode used other alarm bits");
  a_enable_gate: assert property (power_alarm_pending_bits[3] && power_alarm_enable_bits[3] && !integrated |-> irq)
    else $error("enabled pending bit did not raise irq");
  a_force_open: assert property (|alarm_evt |=> line_state == `LINE_OPEN)
    else $error("alarm did not force the line open");
  a_pending_sticky: assert property (power_alarm_pending_bits[4] && clr_mask[4] == 1'b0 |=> power_alarm_pending_bits[4])
    else $error("pending bit dropped without a clear");
  a_total_scale: assert property (tick && integrated |=> total_power_sum == $past(scaled_prod[31:16]))
    else $error("total power not rescaled");
  // software line writes, strobe shape, stored sum, pending set and clear, sign freeze
  a_line_write: assert property (line_wr && !(|alarm_evt) |=> line_state == $past(w_data_q[2:0]))
    else $error("line state write lost");
  a_tick_pulse: assert property (tick |=> !tick)
    else $error("sample strobe longer than one cycle");
  a_sum_hold: assert property (!tick |=> $stable(total_power_sum))
    else $error("total power moved without a sample");
  a_pending_set: assert property (|alarm_evt |=> &(power_alarm_pending_bits | ~$past(alarm_evt)))
    else $error("alarm event did not set its pending bit");
  a_clear_works: assert property (clr_mask[0] && !alarm_evt[0] |=> !power_alarm_pending_bits[0])
    else $error("pending bit survived its clear");
  a_sign_freeze: assert property (tick && cfg[2].pole[`POLE_SIGN] |=> $stable(filt[4].filtered))
    else $error("negative pole moved the filter");
endmodule

//--- thermal_alarm_consts.svh
`ifndef THERMAL_ALARM_CONSTS_SVH
`define THERMAL_ALARM_CONSTS_SVH

// clock and power sample rate
`define CLK_HZ 40000000
`define SAMPLE_RATE_HZ 800
`define SAMPLE_DIV (`CLK_HZ / `SAMPLE_RATE_HZ)

// register byte offsets
`define OFS_TOTAL_SUM 8'h00
`define OFS_PAIR12_THR 8'h04
`define OFS_PAIR34_THR 8'h08
`define OFS_PAIR56_THR 8'h0C
`define OFS_PAIR12_POLE 8'h10
`define OFS_PAIR34_POLE 8'h14
`define OFS_PAIR56_POLE 8'h18
`define OFS_IRQ_PENDING 8'h1C
`define OFS_IRQ_CLEAR 8'h20
`define OFS_IRQ_ENABLE 8'h24
`define OFS_LINE_STATE 8'h28
`define OFS_STATUS 8'h2C

// reset values
`define RST_THRESHOLD 16'hFFFF
`define RST_POLE 16'h0000
`define RST_ENABLE 6'h00
`define RST_LINE_STATE 3'h1

// pole field: sign bit and 12-bit magnitude in bits 14:3
`define POLE_SIGN 15
`define POLE_MSB 14
`define POLE_LSB 3
`define POLE_MASK 16'hFFF8
`define FILT_SHIFT 15

// total power rescale 498/1059.6 as a 16-bit fraction
`define TOTAL_SCALE 16'h7851

// line state and bus responses
`define LINE_OPEN 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- thermal_alarm_pkg.sv
package thermal_alarm_pkg;
  typedef logic [15:0] power_t;

  // threshold and pole of one transistor pair
  typedef struct packed {
    power_t threshold;
    logic [15:0] pole;
  } pair_cfg_s;

  // filter result and comparator output
  typedef struct packed {
    power_t filtered;
    logic over;
  } filt_out_s;
endpackage

//--- sample_tick.sv
`timescale 1ns/1ps
module sample_tick #(
  parameter int unsigned DIV = 50000
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;

  // free-running divider, one-cycle pulse per sample period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule

//--- thermal_lpf.sv
`timescale 1ns/1ps
`include "thermal_alarm_consts.svh"
module thermal_lpf
  import thermal_alarm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire power_t sample,
  input wire pair_cfg_s cfg,
  output filt_out_s out
);
  logic [15:0] coef;
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic signed [19:0] sum;
  power_t next_y;

  // negative pole makes no sense thermally, so it freezes the filter
  assign coef = cfg.pole[`POLE_SIGN] ? 16'h0000 : {1'b0, cfg.pole[`POLE_MSB:`POLE_LSB], 3'b000};
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, out.filtered});
  assign prod = diff * $signed({1'b0, coef});

  // y + coef*(x-y)>>15, clamped to 0..FFFF
  always_comb begin
    sum = $signed({4'h0, out.filtered}) + $signed({prod[33], prod[33:`FILT_SHIFT]});
    if (sum < 0) next_y = 16'h0000;
    else if (sum > 20'sh0FFFF) next_y = 16'hFFFF;
    else next_y = sum[15:0];
  end

  // filter and strict compare move only on the sample tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out <= '0;
    end else if (tick) begin
      out.filtered <= next_y;
      out.over <= next_y > cfg.threshold;
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "thermal_alarm_consts.svh"
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module testbench
  import thermal_alarm_pkg::*;
;
  localparam int DIV = 10; // short sample period keeps the run brief
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, sense = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rr;
  logic [5:0][15:0] tpow = '0;
  power_t tot = 16'h0000;
  logic [2:0] line_state;
  int n_fail = 0, samples_checked = 0;
  typedef struct {logic s; int tr; logic [15:0] p12, p34, p56, t; logic [5:0] exp;} row_s;
  row_s rows[9] = '{
    '{0, 0, 16'h4000, 16'h0000, 16'h0000, 16'h0000, 6'h01},
    '{0, 1, 16'h4000, 16'h0000, 16'h0000, 16'h0000, 6'h02},
    '{0, 2, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 6'h04},
    '{0, 3, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 6'h08},
    '{0, 4, 16'h0000, 16'h0000, 16'h4000, 16'h0000, 6'h10},
    '{0, 5, 16'h0000, 16'h0000, 16'h4000, 16'h04D2, 6'h20},
    '{0, 2, 16'h4000, 16'h0000, 16'h4000, 16'h0000, 6'h00},
    '{1, 4, 16'h4000, 16'h0000, 16'h4000, 16'h06A4, 6'h01},
    '{1, 6, 16'h4000, 16'h0000, 16'h0000, 16'h05DC, 6'h00}};

  always #12.5 aclk = ~aclk;

  thermal_power_alarm_filter #(.SAMPLE_DIV(DIV)) i_thermal_power_alarm_filter (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .thermal_sense_pin(sense), .transistor_power(tpow),
    .total_power(tot), .line_state(line_state), .irq(irq));

  // both channels offered together, each released at its own handshake
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk); // a following call must not re-raise bready in this same step
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk); // a following call must not re-raise rready in this same step
  endtask

  task do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task ticks(input int k);
    repeat (k * DIV) @(posedge aclk);
  endtask

  // poles per pair, one threshold for all; 16'h4000 is 4096/(800*2.5 ms)*8, already whole
  task setup(input logic [15:0] p12, p34, p56, thr, input logic [5:0] en);
    axw(`OFS_PAIR12_POLE, {16'h0, p12}, rr);
    axw(`OFS_PAIR34_POLE, {16'h0, p34}, rr);
    axw(`OFS_PAIR56_POLE, {16'h0, p56}, rr);
    axw(`OFS_PAIR12_THR, {16'h0, thr}, rr);
    axw(`OFS_PAIR34_THR, {16'h0, thr}, rr);
    axw(`OFS_PAIR56_THR, {16'h0, thr}, rr);
    axw(`OFS_IRQ_ENABLE, {26'h0, en}, rr);
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  initial begin
    // each row: fresh reset, at most one transistor hot, 1000 against 750 with a halving filter
    foreach (rows[i]) begin
      sense <= rows[i].s;
      tpow <= '0;
      tot <= rows[i].t;
      do_reset();
      setup(rows[i].p12, rows[i].p34, rows[i].p56, 16'h02EE, 6'h3F);
      if (rows[i].tr < 6) tpow[rows[i].tr] <= 16'h03E8;
      ticks(12);
      axr(`OFS_IRQ_PENDING, rd, rr);
      `CHK("pending", {26'h0, rows[i].exp}, rd)
      `CHK("irq", |rows[i].exp, irq)
      `CHK("line", (rows[i].exp != 0) ? `LINE_OPEN : `RST_LINE_STATE, line_state)
      axr(`OFS_TOTAL_SUM, rd, rr);
      `CHK("sum", rows[i].s ? (32'(rows[i].t) * 32'(`TOTAL_SCALE)) >> 16 : 32'(rows[i].t), rd)
    end
    // reset values and access kinds
    sense <= 1'b0;
    tpow <= '0;
    tot <= 16'h0000;
    do_reset();
    for (int a = 1; a < 7; a++) begin
      axr(8'(a * 4), rd, rr);
      `CHK("reset reg", (a < 4) ? 32'(`RST_THRESHOLD) : 32'(`RST_POLE), rd)
    end
    axr(`OFS_LINE_STATE, rd, rr);
    `CHK("reset line", 32'(`RST_LINE_STATE), rd)
    axw(`OFS_PAIR34_POLE, 32'h0000_4007, rr);
    axr(`OFS_PAIR34_POLE, rd, rr);
    `CHK("pole field", 32'h0000_4000, rd)
    axw(8'h30, 32'h1, rr);
    `CHK("unmapped wr", `RESP_SLVERR, rr)
    axr(8'h30, rd, rr);
    `CHK("unmapped rd", {`RESP_SLVERR, 32'h0}, {rr, rd})
    axw(`OFS_TOTAL_SUM, 32'h1234, rr);
    `CHK("ro wr", `RESP_OKAY, rr)
    axr(`OFS_TOTAL_SUM, rd, rr);
    `CHK("ro kept", 32'h0, rd)
    // masked alarm still forces open, then enable, line write, clear
    setup(16'h4000, 16'h0000, 16'h0000, 16'h02EE, 6'h00);
    tpow[0] <= 16'h03E8;
    ticks(12);
    `CHK("masked irq", 1'b0, irq)
    `CHK("masked open", `LINE_OPEN, line_state)
    axw(`OFS_IRQ_ENABLE, 32'h1, rr);
    `CHK("enabled irq", 1'b1, irq)
    axw(`OFS_LINE_STATE, 32'h3, rr);
    ticks(3);
    `CHK("line written", 3'h3, line_state)
    tpow[0] <= 16'h0000;
    axw(`OFS_IRQ_CLEAR, 32'h1, rr);
    axr(`OFS_IRQ_PENDING, rd, rr);
    `CHK("cleared", 32'h0, rd)
    `CHK("cleared irq", 1'b0, irq)
    // filter settles at 749 for input 750: equal is no alarm, one below is
    do_reset();
    setup(16'h4000, 16'h0000, 16'h0000, 16'h02ED, 6'h3F);
    tpow[0] <= 16'h02EE;
    ticks(20);
    axr(`OFS_IRQ_PENDING, rd, rr);
    `CHK("equal", 32'h0, rd)
    axw(`OFS_PAIR12_THR, 32'h02EC, rr);
    ticks(3);
    axr(`OFS_IRQ_PENDING, rd, rr);
    `CHK("above", 32'h1, rd)
    // a negative pole freezes its filter, so a hot transistor 5 never trips
    axw(`OFS_PAIR56_POLE, 32'h0000_C000, rr);
    tpow[4] <= 16'h03E8;
    ticks(5);
    axr(`OFS_PAIR56_POLE, rd, rr);
    `CHK("sign pole", 32'h0000_C000, rd)
    axr(`OFS_STATUS, rd, rr);
    `CHK("status", 32'h0000_0001, rd)
    conclude();
  end
endmodule
